// *** tb/mhp_assertions.sv ***
/*
  Checker on the host port wires.
  Assumes the bench instantiates it beside mhp_if.
*/
`timescale 1ns/1ps
module mhp_assertions
(
  input wire logic clock,
  input wire logic rst,
  input wire logic chip_select_n,
  input wire logic address_latch_strobe_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic host_bus_oe,
  input wire logic dev_bus_oe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // ==========
  // Bus checks
  a_oe_needs_read: assert property (dev_bus_oe |-> !chip_select_n && !read_strobe_n)
    else $error("device drives bus outside a read");
  a_oe_release: assert property ($rose(read_strobe_n) |-> !dev_bus_oe)
    else $error("device bus not released");
  a_no_contention: assert property (!(dev_bus_oe && host_bus_oe))
    else $error("both ends drive bus");
  a_read_answer: assert property ($fell(read_strobe_n) && !chip_select_n |=> dev_bus_oe)
    else $error("read not answered");
  a_read_hold: assert property ($fell(read_strobe_n) |=> !read_strobe_n)
    else $error("read strobe too short");
  a_read_data_phase: assert property (!read_strobe_n |-> address_latch_strobe_n)
    else $error("read in address phase");
  a_write_selected: assert property (!write_strobe_n |-> !chip_select_n && host_bus_oe)
    else $error("write without select or data");
  a_addr_drive: assert property (!address_latch_strobe_n |-> !chip_select_n && host_bus_oe)
    else $error("address phase not driven");
  a_phase_order: assert property ($fell(chip_select_n) |-> !address_latch_strobe_n)
    else $error("select without address phase");
endmodule

// *** tb/test_mux_host_port_modem_lines.sv ***
/*
  Bench joining host and device ends over mhp_if.
  Assumes a 20 MHz clock and an active-high reset.
*/
`timescale 1ns/1ps
module test_mux_host_port_modem_lines
  import mhp_pkg::*;
;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0, req_write = 1'b0, req_ready, resp_valid;
  logic [7:0] req_addr = 8'h00, req_wdata = 8'h00, resp_rdata, rd, last_bus = 8'h00;
  logic [1:0] cd_n = 2'h3, cts_n = 2'h3, dsr_n = 2'h3, irq_req = 2'h0, dtr_n, irq, irq_oe, carrier;
  int fails = 0, n_compared = 0, cycles = 0;
  mhp_if bus ();
  assign bus.bus_in = bus.host_bus_oe ? bus.host_bus_out : (bus.dev_bus_oe ? bus.dev_bus_out : ~last_bus);
  always @(posedge clock) last_bus <= bus.bus_in;
  always #25 clock = ~clock;
  mhp_host i_mhp_host (.clock(clock), .rst(rst), .bus(bus.host), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready), .resp_valid(resp_valid), .resp_rdata(resp_rdata));
  mhp_device i_mhp_device (.clock(clock), .rst(rst), .bus(bus.device),
    .carrier_detect_n_chan_a(cd_n[0]), .carrier_detect_n_chan_b(cd_n[1]),
    .clear_to_send_n_chan_a(cts_n[0]), .clear_to_send_n_chan_b(cts_n[1]),
    .set_ready_n_chan_a(dsr_n[0]), .set_ready_n_chan_b(dsr_n[1]),
    .irq_req_chan_a(irq_req[0]), .irq_req_chan_b(irq_req[1]),
    .terminal_ready_n_chan_a(dtr_n[0]), .terminal_ready_n_chan_b(dtr_n[1]),
    .irq_out_chan_a(irq[0]), .irq_out_chan_a_oe(irq_oe[0]), .irq_out_chan_b(irq[1]), .irq_out_chan_b_oe(irq_oe[1]),
    .carrier_chan_a(carrier[0]), .carrier_chan_b(carrier[1]));
  mhp_assertions i_mhp_assertions (.clock(clock), .rst(rst), .chip_select_n(bus.chip_select_n),
    .address_latch_strobe_n(bus.address_latch_strobe_n), .read_strobe_n(bus.read_strobe_n),
    .write_strobe_n(bus.write_strobe_n), .host_bus_oe(bus.host_bus_oe), .dev_bus_oe(bus.dev_bus_oe));
  // ==========
  // Tasks
  task check(input logic [7:0] got, input logic [7:0] exp);
    begin
      n_compared++;
      if (got !== exp)
      begin
        fails++;
        $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    begin
      n = 0;
      rd = 'x;
      @(negedge clock);
      while (req_ready !== 1'b1 && n < 20)
      begin
        n++;
        @(negedge clock);
      end
      req_valid = 1'b1;
      req_write = w;
      req_addr = a;
      req_wdata = d;
      @(negedge clock);
      req_valid = 1'b0;
      n = 0;
      while (req_ready !== 1'b1 && n < 20)
      begin
        if (resp_valid === 1'b1)
          rd = resp_rdata;
        n++;
        @(negedge clock);
      end
      @(negedge clock);
    end
  endtask
  task complete_run;
    begin
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fails++;
      complete_run;
    end
  end
  // ==========
  // Tests
  initial
  begin
    repeat (20) @(negedge clock);
    rst = 1'b0;
    check({6'h00, dtr_n}, 8'h03);
    check({5'h00, bus.dev_bus_oe, irq_oe}, 8'h00);
    $display("test reset done");
    for (int c = 0; c < 2; c++)
    begin
      cd_n = c ? 2'h1 : 2'h2;
      dsr_n = c ? 2'h1 : 2'h2;
      cts_n = c ? 2'h2 : 2'h1;
      irq_req = c ? 2'h2 : 2'h1;
      xfer(1'b1, {1'b0, c[0], 6'h04}, 8'h09);
      check({6'h00, dtr_n}, c ? 8'h01 : 8'h02);
      check({4'h0, irq_oe, irq}, c ? 8'h0A : 8'h05);
      check({6'h00, carrier}, c ? 8'h02 : 8'h01);
      xfer(1'b0, {1'b0, c[0], 6'h04}, 8'h00);
      check(rd, 8'h09);
      xfer(1'b0, {1'b0, c[0], 6'h06}, 8'h00);
      check(rd & 8'hB0, 8'hA0);
      xfer(1'b0, {1'b0, ~c[0], 6'h06}, 8'h00);
      check(rd & 8'hB0, 8'h10);
      xfer(1'b1, {1'b0, c[0], 6'h07}, 8'h5A ^ {7'h00, c[0]});
      xfer(1'b0, {1'b0, c[0], 6'h07}, 8'h00);
      check(rd, 8'h5A ^ {7'h00, c[0]});
      xfer(1'b0, {1'b0, c[0], 6'h00}, 8'h00);
      check(rd, 8'h00);
      xfer(1'b1, {1'b0, c[0], 6'h04}, 8'h00);
      check({4'h0, irq_oe, dtr_n}, 8'h03);
      $display("test channel %0d done", c);
    end
    xfer(1'b1, 8'h04, 8'h01);
    check({6'h00, dtr_n}, 8'h02);
    rst = 1'b1;
    @(negedge clock);
    check({6'h00, dtr_n}, 8'h03);
    rst = 1'b0;
    repeat (2) @(negedge clock);
    xfer(1'b0, 8'h04, 8'h00);
    check(rd, 8'h00);
    xfer(1'b0, 8'h47, 8'h00);
    check(rd, 8'h00);
    $display("test second reset done");
    complete_run;
  end
endmodule

// *** verilog/mhp_device.sv ***
/*
  Device end: address latch, per-channel modem control/status/scratch.
  Assumes host strobes synchronous to clock.
*/
`timescale 1ns/1ps
`include "mhp_regs.svh"
module mhp_device
  import mhp_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  mhp_if.device bus,
  input wire logic carrier_detect_n_chan_a,
  input wire logic carrier_detect_n_chan_b,
  input wire logic clear_to_send_n_chan_a,
  input wire logic clear_to_send_n_chan_b,
  input wire logic set_ready_n_chan_a,
  input wire logic set_ready_n_chan_b,
  input wire logic irq_req_chan_a,
  input wire logic irq_req_chan_b,
  output logic terminal_ready_n_chan_a,
  output logic terminal_ready_n_chan_b,
  output logic irq_out_chan_a,
  output logic irq_out_chan_a_oe,
  output logic irq_out_chan_b,
  output logic irq_out_chan_b_oe,
  output logic carrier_chan_a,
  output logic carrier_chan_b
);
  // ==========================================
  // Address latch and strobe edges
  mhp_byte_t addr_reg;
  logic rd_n_reg;
  logic wr_n_reg;
  mhp_byte_t rdata_reg;
  logic oe_reg;
  mhp_byte_t mcr_reg [2];
  mhp_byte_t scr_reg [2];
  mhp_byte_t msr_a;
  mhp_byte_t msr_b;
  mhp_byte_t rd_mux;
  wire selected = !bus.chip_select_n;
  wire data_phase = bus.address_latch_strobe_n;
  wire rd_fall = rd_n_reg && !bus.read_strobe_n && selected && data_phase;
  wire wr_rise = !wr_n_reg && bus.write_strobe_n && selected && data_phase;
  wire chan = addr_reg[`MHP_CHAN_BIT];
  wire [`MHP_REG_ADDR_W-1:0] reg_ofs = addr_reg[`MHP_REG_ADDR_W-1:0];
  wire rd_active = oe_reg && !bus.read_strobe_n && selected;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      addr_reg <= 8'h00;
    else if (selected && !bus.address_latch_strobe_n)
      addr_reg <= bus.bus_in;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rd_n_reg <= 1'b1;
      wr_n_reg <= 1'b1;
    end
    else
    begin
      rd_n_reg <= bus.read_strobe_n;
      wr_n_reg <= bus.write_strobe_n;
    end
  end

  // ==========================================
  // Status bytes
  assign msr_a = {~carrier_detect_n_chan_a, 1'b0, ~set_ready_n_chan_a, ~clear_to_send_n_chan_a, 4'h0};
  assign msr_b = {~carrier_detect_n_chan_b, 1'b0, ~set_ready_n_chan_b, ~clear_to_send_n_chan_b, 4'h0};
  assign carrier_chan_a = ~carrier_detect_n_chan_a;
  assign carrier_chan_b = ~carrier_detect_n_chan_b;

  // ==========================================
  // Register writes
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      mcr_reg[0] <= `MHP_MCR_RESET;
      mcr_reg[1] <= `MHP_MCR_RESET;
      scr_reg[0] <= `MHP_SCR_RESET;
      scr_reg[1] <= `MHP_SCR_RESET;
    end
    else if (wr_rise)
    begin
      if (reg_ofs == `MHP_OFS_MCR)
        mcr_reg[chan] <= bus.bus_in;
      else if (reg_ofs == `MHP_OFS_SCR)
        scr_reg[chan] <= bus.bus_in;
    end
  end

  // ==========================================
  // Read path
  always_comb
  begin
    case (reg_ofs)
      `MHP_OFS_MCR: rd_mux = mcr_reg[chan];
      `MHP_OFS_MSR: rd_mux = chan ? msr_b : msr_a;
      `MHP_OFS_SCR: rd_mux = scr_reg[chan];
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rdata_reg <= 8'h00;
      oe_reg <= 1'b0;
    end
    else if (rd_fall)
    begin
      rdata_reg <= rd_mux;
      oe_reg <= 1'b1;
    end
    else if (bus.read_strobe_n || !selected)
      oe_reg <= 1'b0;
  end

  assign bus.dev_bus_out = rdata_reg;
  assign bus.dev_bus_oe = rd_active;

  // ==========================================
  // Modem outputs
  assign terminal_ready_n_chan_a = ~mcr_reg[0][`MHP_MCR_DTR_BIT];
  assign terminal_ready_n_chan_b = ~mcr_reg[1][`MHP_MCR_DTR_BIT];
  assign irq_out_chan_a = irq_req_chan_a;
  assign irq_out_chan_b = irq_req_chan_b;
  assign irq_out_chan_a_oe = mcr_reg[0][`MHP_MCR_IRQEN_BIT];
  assign irq_out_chan_b_oe = mcr_reg[1][`MHP_MCR_IRQEN_BIT];
endmodule

// *** verilog/mhp_host.sv ***
/*
  Host end: turns a user request into an address then data phase.
  Assumes device answers within the strobe low time.
*/
`timescale 1ns/1ps
`include "mhp_regs.svh"
module mhp_host
  import mhp_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  mhp_if.host bus,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [7:0] req_addr,
  input wire logic [7:0] req_wdata,
  output logic req_ready,
  output logic resp_valid,
  output logic [7:0] resp_rdata
);
  mhp_host_state_e state_reg;
  mhp_host_state_e state_next;
  logic [1:0] cnt_reg;
  logic write_reg;
  mhp_byte_t addr_reg;
  mhp_byte_t wdata_reg;
  logic resp_valid_reg;
  mhp_byte_t rdata_reg;
  wire cnt_done = (cnt_reg == 2'(`MHP_STROBE_LOW_CYC - 1));

  // ==========================================
  // Sequencer
  always_comb
  begin
    case (state_reg)
      MHP_HOST_IDLE: state_next = req_valid ? MHP_HOST_ADDR : MHP_HOST_IDLE;
      MHP_HOST_ADDR: state_next = MHP_HOST_DATA;
      MHP_HOST_DATA: state_next = cnt_done ? MHP_HOST_END : MHP_HOST_DATA;
      MHP_HOST_END: state_next = MHP_HOST_IDLE;
      default: state_next = MHP_HOST_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= MHP_HOST_IDLE;
      cnt_reg <= 2'h0;
      write_reg <= 1'b0;
      addr_reg <= 8'h00;
      wdata_reg <= 8'h00;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= (state_reg == MHP_HOST_DATA) ? cnt_reg + 2'h1 : 2'h0;
      if (state_reg == MHP_HOST_IDLE && req_valid)
      begin
        write_reg <= req_write;
        addr_reg <= req_addr;
        wdata_reg <= req_wdata;
      end
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      resp_valid_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end
    else
    begin
      resp_valid_reg <= (state_reg == MHP_HOST_DATA) && cnt_done && !write_reg;
      if ((state_reg == MHP_HOST_DATA) && cnt_done && !write_reg)
        rdata_reg <= bus.bus_in;
    end
  end

  // ==========================================
  // Pin drive
  wire in_xfer = (state_reg != MHP_HOST_IDLE);
  wire strobing = (state_reg == MHP_HOST_DATA);
  assign req_ready = (state_reg == MHP_HOST_IDLE);
  assign bus.chip_select_n = ~in_xfer;
  assign bus.address_latch_strobe_n = ~(state_reg == MHP_HOST_ADDR);
  assign bus.read_strobe_n = ~(strobing && !write_reg);
  assign bus.write_strobe_n = ~(strobing && write_reg);
  assign bus.host_bus_out = (state_reg == MHP_HOST_ADDR) ? addr_reg : wdata_reg;
  assign bus.host_bus_oe = (state_reg == MHP_HOST_ADDR) || (write_reg && (strobing || state_reg == MHP_HOST_END));
  assign resp_valid = resp_valid_reg;
  assign resp_rdata = rdata_reg;
endmodule

// *** verilog/mhp_if.sv ***
/*
  Pins between host and device: shared bus as three signals per side.
  Assumes the testbench resolves the bus wire from the enables.
*/
`timescale 1ns/1ps
interface mhp_if;
  import mhp_pkg::*;
  logic chip_select_n;
  logic address_latch_strobe_n;
  logic read_strobe_n;
  logic write_strobe_n;
  mhp_byte_t host_bus_out;
  logic host_bus_oe;
  mhp_byte_t dev_bus_out;
  logic dev_bus_oe;
  mhp_byte_t bus_in;
  modport device
  (
    input chip_select_n, address_latch_strobe_n, read_strobe_n, write_strobe_n, bus_in,
    output dev_bus_out, dev_bus_oe
  );
  modport host
  (
    output chip_select_n, address_latch_strobe_n, read_strobe_n, write_strobe_n, host_bus_out, host_bus_oe,
    input bus_in
  );
endinterface

// *** verilog/mhp_pkg.sv ***
/*
  Types shared by both ends of the host port.
  Assumes mhp_regs.svh is on the include path.
*/
`include "mhp_regs.svh"
package mhp_pkg;
  typedef logic [`MHP_BUS_W-1:0] mhp_byte_t;
  typedef enum logic [1:0] {MHP_HOST_IDLE, MHP_HOST_ADDR, MHP_HOST_DATA, MHP_HOST_END} mhp_host_state_e;
endpackage

// *** verilog/mhp_regs.svh ***
/*
  Constants for the multiplexed host port with modem lines.
  Assumes inclusion by the package and both ends; no processes here.
*/
`ifndef MHP_REGS_SVH
`define MHP_REGS_SVH

`define MHP_BUS_W 8
`define MHP_CHAN_BIT 6
`define MHP_REG_ADDR_W 3
`define MHP_OFS_MCR 3'h4
`define MHP_OFS_MSR 3'h6
`define MHP_OFS_SCR 3'h7
`define MHP_MCR_DTR_BIT 0
`define MHP_MCR_IRQEN_BIT 3
`define MHP_MSR_CTS_BIT 4
`define MHP_MSR_DSR_BIT 5
`define MHP_MSR_CD_BIT 7
`define MHP_MCR_RESET 8'h00
`define MHP_SCR_RESET 8'h00
`define MHP_STROBE_LOW_CYC 2
`define MHP_GAP_CYC 1

`endif
